//--- hdl/crch_ctrl.sv
// Host controller that drives the CRC engine through its byte register port
`timescale 1ns/1ps
`default_nettype none
module crch_ctrl
  import crch_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output var  logic [31:0] avs_readdata_o,
  output var  logic        avs_waitrequest_o,
  // Device byte register port
  output var  logic [7:0]  sfr_addr_o,
  output var  logic [7:0]  sfr_wdata_o,
  output var  logic        sfr_we_o,
  output var  logic        sfr_re_o,
  input  wire logic [7:0]  sfr_rdata_i,
  // Completion of the external DMA channel
  input  wire logic        dma_done_i
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised inputs

  logic [7:0] rdata_s;
  logic       dma_done_s;

  crch_sync #(.W(9)) u_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .d_i      ({dma_done_i, sfr_rdata_i}),
    .q_o      ({dma_done_s, rdata_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Host registers

  crch_state_t      state_r;
  crch_state_t      state_nxt;
  logic [CFG_W-1:0] cfg_r;
  logic [15:0]      poly_r;
  logic [15:0]      result_r;
  logic [7:0]       data_r;
  logic             done_r;
  logic             wait_r;
  logic [31:0]      rdata_r;
  logic             op_pend_r;

  wire sel_cfg    = (avs_address_i == HR_CONFIG);
  wire sel_cmd    = (avs_address_i == HR_CMD);
  wire sel_poly   = (avs_address_i == HR_POLY);
  wire sel_data   = (avs_address_i == HR_DATA);
  wire sel_status = (avs_address_i == HR_STATUS);
  wire sel_result = (avs_address_i == HR_RESULT);

  wire in_idle   = (state_r == S_IDLE);
  wire in_ready  = (state_r == S_READY);
  // Commands and data stall the bus until the sequencer can take them
  wire acc_ok    = (sel_cmd || sel_data) ? (in_idle || in_ready) : 1'b1;
  wire bus_req   = avs_read_i || avs_write_i;
  wire wr_acc    = avs_write_i && !wait_r;
  wire start_cmd = wr_acc && sel_cmd && avs_writedata_i[CMD_START] && in_idle;
  wire fin_cmd   = wr_acc && sel_cmd && avs_writedata_i[CMD_FINISH] && in_ready;
  wire data_take = wr_acc && sel_data && in_ready;

  wire [3:0] status_w;
  assign status_w[ST_BIT_DONE]     = done_r;
  assign status_w[ST_BIT_ACTIVE]   = !in_idle;
  assign status_w[ST_BIT_READY]    = in_ready;
  assign status_w[ST_BIT_DMA_WAIT] = (state_r == S_DMA_WAIT);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_cfg) begin
      rd_mux = {27'h000_0000, cfg_r};
    end else if (sel_poly) begin
      rd_mux = {16'h0000, poly_r};
    end else if (sel_status) begin
      rd_mux = {28'h000_0000, status_w};
    end else if (sel_result) begin
      rd_mux = {16'h0000, result_r};
    end
  end

  // Every access is answered one cycle after acc_ok lets it through: waitrequest idles high
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else if (!wait_r) begin
      wait_r <= 1'b1;
    end else if (bus_req && acc_ok) begin
      wait_r  <= 1'b0;
      rdata_r <= rd_mux;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_r  <= CFG_RESET;
      poly_r <= POLY_RESET;
    end else if (wr_acc && sel_cfg) begin
      cfg_r <= avs_writedata_i[CFG_W-1:0];
    end else if (wr_acc && sel_poly) begin
      poly_r <= avs_writedata_i[15:0];
    end
  end

  assign avs_readdata_o    = rdata_r;
  assign avs_waitrequest_o = wait_r;

  ////////////////////////////////////////////////////////////////////////////
  // Device access sequencing

  logic [7:0] byte_rev;
  always_comb begin
    byte_rev = 8'h00;
    for (int i = 0; i < 8; i++) begin
      byte_rev[i] = data_r[7-i];
    end
  end

  // Polynomial always goes out MSB first; only data bytes are reversed
  wire [7:0] data_out = cfg_r[CFG_LSB_FIRST] ? byte_rev : data_r;

  wire op_read  = (state_r == S_RD_LO) || (state_r == S_RD_HI);
  wire op_state = !(in_idle || in_ready || (state_r == S_DMA_WAIT));
  wire op_start = op_state && !op_pend_r;
  logic op_done;

  logic [7:0] ctl_seed;
  logic [7:0] ctl_final;
  always_comb begin
    ctl_seed = CTL_ALL_CLEAR;
    ctl_seed[CTL_PRESET_POL] = cfg_r[CFG_SEED_ONES];
    ctl_final = CTL_ALL_CLEAR;
    ctl_final[CTL_COMPLEMENT] = cfg_r[CFG_COMPLEMENT];
    ctl_final[CTL_MIRROR]     = cfg_r[CFG_MIRROR];
  end

  logic [7:0] op_addr;
  logic [7:0] op_wdata;
  always_comb begin
    op_addr  = DEV_CONTROL;
    op_wdata = CTL_ALL_CLEAR;
    case (state_r)
      S_SEED_SET: begin
        op_wdata = ctl_seed;
      end
      S_REINIT: begin
        op_wdata = ctl_seed;
        op_wdata[CTL_REINIT] = 1'b1;
      end
      S_SEED_CLR: begin
        op_wdata = CTL_ALL_CLEAR;
      end
      S_POLY_LO: begin
        op_addr  = DEV_POLY_LO;
        op_wdata = {poly_r[7:1], 1'b1};
      end
      S_POLY_HI: begin
        op_addr  = DEV_POLY_HI;
        op_wdata = poly_r[15:8];
      end
      S_BYTE_WR: begin
        op_addr  = DEV_BYTE_INPUT;
        op_wdata = data_out;
      end
      S_DMA_GO: begin
        // Auto mode is raised as soon as the polynomial high byte is written; nothing waits on software or the channel
        op_wdata[CTL_AUTO_XFER] = 1'b1;
      end
      S_FIN_CTL: begin
        // Auto transfer bit drops here together with the final adjustments
        op_wdata = ctl_final;
      end
      S_RD_LO: begin
        op_addr = DEV_RESULT_LO;
      end
      S_RD_HI: begin
        op_addr = DEV_RESULT_HI;
      end
      S_CLR_CTL: begin
        op_wdata = CTL_ALL_CLEAR;
      end
      default: begin
        op_addr  = DEV_CONTROL;
        op_wdata = CTL_ALL_CLEAR;
      end
    endcase
  end

  crch_sfr_port u_port (
    .clk_i       (clk_i),
    .arst_n_i    (arst_n_i),
    .start_i     (op_start),
    .read_i      (op_read),
    .addr_i      (op_addr),
    .wdata_i     (op_wdata),
    .done_o      (op_done),
    .sfr_addr_o  (sfr_addr_o),
    .sfr_wdata_o (sfr_wdata_o),
    .sfr_we_o    (sfr_we_o),
    .sfr_re_o    (sfr_re_o)
  );

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (start_cmd) begin
          state_nxt = cfg_r[CFG_SEED_ONES] ? S_SEED_SET : S_REINIT;
        end
      end
      S_SEED_SET: state_nxt = op_done ? S_REINIT : S_SEED_SET;
      S_REINIT:   state_nxt = op_done ? S_SEED_CLR : S_REINIT;
      S_SEED_CLR: state_nxt = op_done ? S_POLY_LO : S_SEED_CLR;
      S_POLY_LO:  state_nxt = op_done ? S_POLY_HI : S_POLY_LO;
      S_POLY_HI: begin
        if (op_done) begin
          state_nxt = cfg_r[CFG_DMA] ? S_DMA_GO : S_READY;
        end
      end
      S_READY: begin
        if (data_take) begin
          state_nxt = S_BYTE_WR;
        end else if (fin_cmd) begin
          state_nxt = S_FIN_CTL;
        end
      end
      S_BYTE_WR: state_nxt = op_done ? S_READY : S_BYTE_WR;
      S_DMA_GO:  state_nxt = op_done ? S_DMA_WAIT : S_DMA_GO;
      S_DMA_WAIT: begin
        // Channel set up by software reports completion here
        if (dma_done_s) begin
          state_nxt = S_FIN_CTL;
        end
      end
      S_FIN_CTL: state_nxt = op_done ? S_RD_LO : S_FIN_CTL;
      S_RD_LO:   state_nxt = op_done ? S_RD_HI : S_RD_LO;
      S_RD_HI:   state_nxt = op_done ? S_CLR_CTL : S_RD_HI;
      S_CLR_CTL: state_nxt = op_done ? S_IDLE : S_CLR_CTL;
      default:   state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r   <= S_IDLE;
      op_pend_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      op_pend_r <= op_done ? 1'b0 : (op_pend_r || op_start);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_r   <= 8'h00;
      result_r <= 16'h0000;
      done_r   <= 1'b0;
    end else begin
      if (data_take) begin
        data_r <= avs_writedata_i[7:0];
      end
      if (op_done && state_r == S_RD_LO) begin
        result_r[7:0] <= rdata_s;
      end
      if (op_done && state_r == S_RD_HI) begin
        result_r[15:8] <= rdata_s;
      end
      if (op_done && state_r == S_CLR_CTL) begin
        done_r <= 1'b1;
      end else if (start_cmd) begin
        done_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [7:0] ctl_shadow_r;
  logic       poly_ok_r;
  logic       dma_pend_r;
  wire ctl_wr  = sfr_we_o && (sfr_addr_o == DEV_CONTROL);
  wire byte_wr = sfr_we_o && (sfr_addr_o == DEV_BYTE_INPUT);
  // Bit order spelled out apart from the datapath reversal it checks
  wire [7:0] data_rev_chk = {data_r[0], data_r[1], data_r[2], data_r[3],
                             data_r[4], data_r[5], data_r[6], data_r[7]};

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctl_shadow_r <= 8'h00;
      poly_ok_r    <= 1'b0;
      dma_pend_r   <= 1'b0;
    end else begin
      if (ctl_wr) begin
        ctl_shadow_r <= sfr_wdata_o;
      end
      if (ctl_wr && sfr_wdata_o[CTL_REINIT]) begin
        poly_ok_r <= 1'b0;
      end else if (sfr_we_o && sfr_addr_o == DEV_POLY_HI) begin
        poly_ok_r <= 1'b1;
      end
      if (ctl_wr && sfr_wdata_o[CTL_AUTO_XFER]) begin
        dma_pend_r <= 1'b1;
      end else if (dma_done_s) begin
        dma_pend_r <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  chk_poly_lsb_set: assert property (
    sfr_we_o && sfr_addr_o == DEV_POLY_LO |-> sfr_wdata_o[0])
    else $error("polynomial low byte written with bit 0 clear");

  chk_seed_then_clear: assert property (
    ctl_wr && sfr_wdata_o[CTL_REINIT] |-> ##[1:4] (ctl_wr && sfr_wdata_o == CTL_ALL_CLEAR))
    else $error("seed polarity not cleared after reinit");

  chk_poly_before_data: assert property (
    byte_wr |-> poly_ok_r)
    else $error("data byte written before polynomial after reinit");

  chk_final_bits_clear: assert property (
    byte_wr |-> !ctl_shadow_r[CTL_COMPLEMENT] && !ctl_shadow_r[CTL_MIRROR])
    else $error("data byte written with result adjustments active");

  chk_dma_bit_drop: assert property (
    state_r == S_DMA_WAIT && dma_done_s |=> ##[0:2] (ctl_wr && !sfr_wdata_o[CTL_AUTO_XFER]))
    else $error("auto transfer bit not cleared after completion");

  chk_read_after_dma: assert property (
    sfr_re_o |-> !dma_pend_r)
    else $error("result read while DMA transfer pending");

  chk_one_strobe: assert property (
    sfr_we_o || sfr_re_o |=> !sfr_we_o && !sfr_re_o)
    else $error("back-to-back device strobes");

  chk_lsb_reverse: assert property (
    op_start && state_r == S_BYTE_WR && cfg_r[CFG_LSB_FIRST]
      |=> byte_wr && sfr_wdata_o == $past(data_rev_chk))
    else $error("LSB-first byte not reversed");

  chk_wait_answer: assert property (
    bus_req && wait_r && acc_ok |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not one cycle after request");

  cov_dma_session: cover property (
    state_r == S_DMA_WAIT ##[1:1000] (state_r == S_IDLE && done_r));
  cov_seed_ones: cover property (ctl_wr && sfr_wdata_o[CTL_PRESET_POL]);
  cov_lsb_byte: cover property (byte_wr && cfg_r[CFG_LSB_FIRST]);

endmodule
`default_nettype wire

//--- hdl/crch_pkg.sv
// Package: register maps, field positions, states and timing for the CRC host controller
package crch_pkg;

  // Device register addresses on its byte port
  localparam logic [7:0] DEV_BYTE_INPUT = 8'hb9;
  localparam logic [7:0] DEV_RESULT_LO  = 8'hba;
  localparam logic [7:0] DEV_RESULT_HI  = 8'hbb;
  localparam logic [7:0] DEV_POLY_LO    = 8'hbc;
  localparam logic [7:0] DEV_POLY_HI    = 8'hbd;
  localparam logic [7:0] DEV_CONTROL    = 8'hbe;

  // Device control bit positions
  localparam int CTL_PRESET_POL = 0;
  localparam int CTL_COMPLEMENT = 1;
  localparam int CTL_MIRROR     = 2;
  localparam int CTL_AUTO_XFER  = 3;
  localparam int CTL_REINIT     = 7;
  localparam logic [7:0] CTL_ALL_CLEAR = 8'h00;

  // Host register byte offsets on the Avalon side
  localparam logic [4:0] HR_CONFIG = 5'h00;
  localparam logic [4:0] HR_CMD    = 5'h04;
  localparam logic [4:0] HR_POLY   = 5'h08;
  localparam logic [4:0] HR_DATA   = 5'h0c;
  localparam logic [4:0] HR_STATUS = 5'h10;
  localparam logic [4:0] HR_RESULT = 5'h14;

  // Config fields
  localparam int CFG_SEED_ONES  = 0;
  localparam int CFG_COMPLEMENT = 1;
  localparam int CFG_MIRROR     = 2;
  localparam int CFG_DMA        = 3;
  localparam int CFG_LSB_FIRST  = 4;
  localparam int CFG_W          = 5;
  localparam logic [CFG_W-1:0] CFG_RESET  = 5'h00;
  localparam logic [15:0]      POLY_RESET = 16'h0000;

  // Command fields
  localparam int CMD_START  = 0;
  localparam int CMD_FINISH = 1;

  // Status fields
  localparam int ST_BIT_DONE     = 0;
  localparam int ST_BIT_ACTIVE   = 1;
  localparam int ST_BIT_READY    = 2;
  localparam int ST_BIT_DMA_WAIT = 3;

  // Cycles from a read strobe until read data is valid behind the synchroniser
  localparam int SFR_RD_WAIT = 3;

  typedef enum logic [3:0] {
    S_IDLE     = 4'h0,
    S_SEED_SET = 4'h1,
    S_REINIT   = 4'h2,
    S_SEED_CLR = 4'h3,
    S_POLY_LO  = 4'h4,
    S_POLY_HI  = 4'h5,
    S_READY    = 4'h6,
    S_BYTE_WR  = 4'h7,
    S_DMA_GO   = 4'h8,
    S_DMA_WAIT = 4'h9,
    S_FIN_CTL  = 4'ha,
    S_RD_LO    = 4'hb,
    S_RD_HI    = 4'hc,
    S_CLR_CTL  = 4'hd
  } crch_state_t;

endpackage

//--- hdl/crch_sfr_port.sv
// Single-access sequencer for the device byte register port
`timescale 1ns/1ps
`default_nettype none
module crch_sfr_port
  import crch_pkg::*;
#(
  parameter int RD_WAIT = SFR_RD_WAIT
) (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       start_i,
  input  wire logic       read_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output var  logic       done_o,
  output var  logic [7:0] sfr_addr_o,
  output var  logic [7:0] sfr_wdata_o,
  output var  logic       sfr_we_o,
  output var  logic       sfr_re_o
);
  logic [3:0] wait_r;
  logic       rd_pend_r;

  wire rd_last = rd_pend_r && (wait_r == 4'h1);

  // Strobes last one cycle, so each access moves exactly one byte
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sfr_addr_o  <= 8'h00;
      sfr_wdata_o <= 8'h00;
      sfr_we_o    <= 1'b0;
      sfr_re_o    <= 1'b0;
      done_o      <= 1'b0;
      wait_r      <= 4'h0;
      rd_pend_r   <= 1'b0;
    end else begin
      sfr_we_o <= start_i && !read_i;
      sfr_re_o <= start_i && read_i;
      done_o   <= (start_i && !read_i) || rd_last;
      if (start_i) begin
        sfr_addr_o  <= addr_i;
        sfr_wdata_o <= read_i ? 8'h00 : wdata_i;
        rd_pend_r   <= read_i;
        wait_r      <= 4'(RD_WAIT);
      end else if (rd_pend_r) begin
        wait_r    <= wait_r - 4'h1;
        rd_pend_r <= !rd_last;
      end
    end
  end
endmodule
`default_nettype wire

//--- hdl/crch_sync.sv
// Two-flop synchroniser for inputs arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module crch_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule
`default_nettype wire

//--- verification/crch_ctrl_test.sv
// Self-checking bench for the CRC host controller driving the behavioural engine
`timescale 1ns/1ps
`default_nettype none
module crch_ctrl_test;
  import crch_pkg::*;
  logic        clk_i;
  logic        arst_n_i;
  logic [4:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [7:0]  sfr_addr;
  logic [7:0]  sfr_wdata;
  logic        sfr_we;
  logic        sfr_re;
  logic [7:0]  sfr_rdata;
  logic        dma_done;
  logic [7:0]  dma_len;
  int          n_mismatch = 0;
  int          comparisons = 0;
  crch_ctrl dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .sfr_addr_o(sfr_addr), .sfr_wdata_o(sfr_wdata), .sfr_we_o(sfr_we), .sfr_re_o(sfr_re),
    .sfr_rdata_i(sfr_rdata), .dma_done_i(dma_done));
  crch_dev_model dev_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .sfr_addr_i(sfr_addr),
    .sfr_wdata_i(sfr_wdata), .sfr_we_i(sfr_we), .sfr_re_i(sfr_re), .dma_len_i(dma_len),
    .sfr_rdata_o(sfr_rdata), .dma_done_o(dma_done));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] ref_step(input logic [15:0] c, input logic [7:0] b,
                                           input logic [15:0] p);
    for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? p : 16'h0000);
    return c;
  endfunction
  function automatic logic [15:0] rev(input logic [15:0] v, input int w);
    rev = 16'h0000;
    for (int i = 0; i < w; i++) rev[i] = v[w-1-i];
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Holds the request until waitrequest is sampled low, then lets one edge pass
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 2000);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
    if (n >= 2000) check("waitrequest", 32'h0, 32'h1);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    av(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string what, input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    av(1'b0, a, 32'h0, q);
    check(what, exp, q);
  endtask
  // One whole computation; the expected value is built from the engine's rules
  task automatic session(input string name, input logic [4:0] cfg, input logic [15:0] poly,
                         input int n);
    logic [15:0] c;
    logic [15:0] rv;
    logic [31:0] q;
    logic [7:0]  b;
    int          k;
    c = {16{cfg[CFG_SEED_ONES]}};
    q = 32'h0;
    dma_len <= n[7:0];
    wr(HR_CONFIG, {27'h0, cfg});
    wr(HR_POLY, {16'h0, poly});
    wr(HR_CMD, 32'h1);
    for (k = 0; k < n; k++) begin
      b = 8'h31 + k[7:0];
      if (!cfg[CFG_DMA]) wr(HR_DATA, {24'h0, b});
      rv = rev({8'h0, b}, 8);
      c = ref_step(c, cfg[CFG_LSB_FIRST] ? rv[7:0] : b, poly | 16'h0001);
    end
    if (!cfg[CFG_DMA]) begin
      for (k = 0; k < 300 && q[ST_BIT_READY] !== 1'b1; k++) av(1'b0, HR_STATUS, 32'h0, q);
      check({name, " ready"}, 32'h6, q);
      wr(HR_CMD, 32'h2);
    end
    q = 32'h0;
    for (k = 0; k < 300 && q[ST_BIT_DONE] !== 1'b1; k++) av(1'b0, HR_STATUS, 32'h0, q);
    check({name, " done"}, 32'h1, q);
    if (cfg[CFG_COMPLEMENT]) c = ~c;
    if (cfg[CFG_MIRROR]) c = rev(c, 16);
    av(1'b0, HR_RESULT, 32'h0, q);
    check({name, " result"}, {16'h0, c}, q);
    check({name, " bytes"}, n, {24'h0, dev_u.byte_cnt});
    check({name, " order"}, 32'h0, {24'h0, dev_u.seq_err});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd_chk("config reset", HR_CONFIG, {27'h0, CFG_RESET});
    rd_chk("poly reset", HR_POLY, {16'h0, POLY_RESET});
    rd_chk("result reset", HR_RESULT, 32'h0);
    wr(5'h01, 32'h1f);
    rd_chk("unaligned write", HR_CONFIG, 32'h0);
    rd_chk("unmapped read", 5'h18, 32'h0);
    wr(HR_CONFIG, 32'h15);
    rd_chk("config rw", HR_CONFIG, 32'h15);
    wr(HR_POLY, 32'habcd);
    rd_chk("poly rw", HR_POLY, 32'habcd);
    $display("t_regs done");
  endtask
  task automatic t_cpu;
    session("plain", 5'h00, 16'h1021, 9);
    session("empty", 5'h01, 16'h1021, 0);
    $display("t_cpu done");
  endtask
  task automatic t_opts;
    for (int m = 0; m < 4; m++) session("opts", {2'b00, m[1:0], 1'b1}, 16'h8005, 5);
    $display("t_opts done");
  endtask
  task automatic t_lsb;
    session("lsb", 5'h10, 16'h8005, 4);
    $display("t_lsb done");
  endtask
  task automatic t_dma;
    session("dma", 5'h09, 16'h1020, 12);
    session("dma one", 5'h08, 16'h3d65, 1);
    $display("t_dma done");
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    n_mismatch++;
    $display("watchdog expired");
    final_report();
  end
  initial begin
    {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i, dma_len} = '0;
    arst_n_i = 1'b0;
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    t_regs();
    t_cpu();
    t_opts();
    t_lsb();
    t_dma();
    final_report();
  end
endmodule
`default_nettype wire

//--- verification/crch_dev_model.sv
// Behavioural CRC engine behind its byte register port, with a simple DMA feeder
`timescale 1ns/1ps
`default_nettype none
module crch_dev_model
  import crch_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_we_i,
  input  wire logic       sfr_re_i,
  input  wire logic [7:0] dma_len_i,
  output var  logic [7:0] sfr_rdata_o,
  output var  logic       dma_done_o
);
  logic [15:0] crc_r;
  logic [15:0] poly_r;
  logic [15:0] cpl;
  logic [15:0] view;
  logic [7:0]  ctl_r;
  logic [7:0]  dma_idx;
  logic [7:0]  byte_cnt;
  logic [7:0]  seq_err;
  logic [7:0]  rd_val;
  logic [2:0]  hold_cnt;
  function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] b,
                                       input logic [15:0] p);
    for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? p : 16'h0000);
    return c;
  endfunction
  function automatic logic [15:0] mir(input logic [15:0] v);
    for (int i = 0; i < 16; i++) mir[i] = v[15-i];
  endfunction
  assign cpl  = ctl_r[CTL_COMPLEMENT] ? ~crc_r : crc_r;
  assign view = ctl_r[CTL_MIRROR] ? mir(cpl) : cpl;
  assign rd_val = sfr_addr_i == DEV_RESULT_LO ? view[7:0] :
                  sfr_addr_i == DEV_RESULT_HI ? view[15:8] :
                  sfr_addr_i == DEV_POLY_LO ? poly_r[7:0] :
                  sfr_addr_i == DEV_POLY_HI ? poly_r[15:8] :
                  sfr_addr_i == DEV_CONTROL ? ctl_r : 8'h00;
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {crc_r, poly_r, ctl_r, dma_idx, byte_cnt, seq_err} <= '0;
      {sfr_rdata_o, hold_cnt, dma_done_o} <= '0;
    end else begin
      if (sfr_we_i && sfr_addr_i == DEV_BYTE_INPUT) begin
        crc_r <= step(crc_r, sfr_wdata_i, poly_r);
        byte_cnt <= byte_cnt + 8'h01;
        if (!poly_r[0]) seq_err <= seq_err + 8'h01;
      end
      if (sfr_we_i && sfr_addr_i == DEV_POLY_LO) poly_r[7:0] <= sfr_wdata_i;
      if (sfr_we_i && sfr_addr_i == DEV_POLY_HI) poly_r[15:8] <= sfr_wdata_i;
      if (sfr_we_i && sfr_addr_i == DEV_CONTROL) begin
        ctl_r <= sfr_wdata_i & 8'h0f;
        if (sfr_wdata_i[CTL_REINIT]) begin
          crc_r <= {16{sfr_wdata_i[CTL_PRESET_POL]}};
          byte_cnt <= 8'h00;
        end
      end
      // Feeds ascending bytes only while the engine sits in autonomous mode
      if (ctl_r[CTL_AUTO_XFER] && dma_idx < dma_len_i) begin
        crc_r <= step(crc_r, 8'h31 + dma_idx, poly_r);
        dma_idx <= dma_idx + 8'h01;
        byte_cnt <= byte_cnt + 8'h01;
        if (!poly_r[0]) seq_err <= seq_err + 8'h01;
      end
      // Channel restarts from offset zero and never wraps past its count
      if (!ctl_r[CTL_AUTO_XFER]) dma_idx <= 8'h00;
      dma_done_o <= ctl_r[CTL_AUTO_XFER] && dma_idx == dma_len_i;
      // Read data holds five cycles, then toggles so a late capture shows up
      if (sfr_re_i) begin
        sfr_rdata_o <= rd_val;
        hold_cnt <= 3'h4;
      end else if (hold_cnt != 3'h0) hold_cnt <= hold_cnt - 3'h1;
      else sfr_rdata_o <= ~sfr_rdata_o;
    end
  end
endmodule
`default_nettype wire
